// [src/lpc_ctrl.sv]
// Low power mode controller: APB registers, write protection, mode sequencing
`timescale 1ns/1ps
`include "lpc_map.svh"
// ==============================================================
// Overview of operation
// - Operable unit runs per its stop bit
// - Stopped unit keeps its register contents
// - Power mode codes 000, 010, 100 decoded
// - Return clock codes 000, 001, 010 decoded
// - Low-power protect gates mode, stop, snooze
// - Third protect gates reset, timer registers
// - Clock protect gates clock generation registers
// - Fourth protect gates voltage detect registers
// - Deep sleep enable turns sleep into deep
// - Stop A bit halts transfer controller
// - Stop B bit 0 halts CAN; D exists
// - Standby enters snooze on trigger
// - Snooze ends on interrupt or end
module lpc_ctrl
    import lpc_pkg::*;
#(
    parameter int NBANK = `LPC_BANK_WORDS
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            sys_rst,
    // APB slave
    input  wire lpc_apb_req_type apb_req,
    output lpc_apb_rsp_type      apb_rsp,
    // Power events
    input  wire logic            sleep_req,
    input  wire logic            wake_irq,
    input  wire logic            snooze_trigger,
    input  wire logic            snooze_end,
    // Unit control
    output logic [3:0][31:0]     unit_clock_enable,
    output logic [3:0][31:0]     unit_retain,
    // Mode and clock selection
    output lpc_mode_type         power_state,
    output logic [2:0]           speed_select,
    output logic [2:0]           return_clock_onehot,
    output logic                 clock_switch_pulse,
    output logic [NBANK-1:0][31:0] bank_regs
);

// ==============================================================
// Registers
lpc_prot_type      write_protect;
logic [3:0][31:0]  module_stop;
logic [2:0]        power_mode_field;
logic              return_clock_switch_enable;
logic [2:0]        return_clock_select;
lpc_mode_type      next_state;

// ==============================================================
// Address decode
wire        acc_setup = apb_req.psel & ~apb_req.penable;
wire        acc_write = apb_req.psel & apb_req.penable & apb_req.pwrite;
wire [7:0]  addr      = apb_req.paddr;
wire [31:0] wdata     = apb_req.pwdata;
wire        hit_prot  = (addr == `LPC_OFF_PROT);
wire        hit_pwr   = (addr == `LPC_OFF_PWR);
wire        hit_ret   = (addr == `LPC_OFF_RET);
wire        hit_stat  = (addr == `LPC_OFF_STAT);
wire [4:0]  bank_idx  = addr[6:2];
wire        hit_bank  = addr[7] & (addr[1:0] == 2'h0) & (int'(bank_idx) < NBANK);
wire [1:0]  stop_idx  = 2'(addr[5:2] - 4'h1);
wire        hit_stop  = (addr[7:6] == 2'h0) & (addr[1:0] == 2'h0)
                      & (addr[5:2] >= 4'h1) & (addr[5:2] <= 4'h4);
wire        hit_any   = hit_prot | hit_pwr | hit_ret | hit_stat | hit_bank | hit_stop;

// Guard of each bank word by its index range
wire bank_open = (bank_idx <= `LPC_LOWP_LAST) ? write_protect.lowp :
                 (bank_idx <= `LPC_RTMR_LAST) ? write_protect.rtmr :
                 (bank_idx <= `LPC_VDET_LAST) ? write_protect.vdet :
                 write_protect.clk;

// Writes dropped silently; software sees no error, only unchanged contents
wire wr_prot = acc_write & hit_prot;
wire wr_stop = acc_write & hit_stop & write_protect.lowp;
wire wr_pwr  = acc_write & hit_pwr & write_protect.lowp;
wire wr_ret  = acc_write & hit_ret & write_protect.lowp;
wire wr_bank = acc_write & hit_bank & bank_open;

// ==============================================================
// Register storage
always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
        write_protect              <= `LPC_PROT_RST;
        power_mode_field           <= `LPC_SPD_HIGH;
        return_clock_switch_enable <= 1'b0;
        return_clock_select        <= `LPC_RET_LOW_SPEED_ONCHIP_OSC;
    end else begin
        if (wr_prot) begin
            write_protect <= wdata[3:0];
        end
        if (wr_pwr) begin
            power_mode_field <= wdata[2:0];
        end
        if (wr_ret) begin
            return_clock_switch_enable <= wdata[`LPC_RET_EN];
            return_clock_select        <= wdata[2:0];
        end
    end
end

genvar g;
generate
    for (g = 0; g < 4; g++) begin : g_stop
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                module_stop[g] <= `LPC_MSTP_RST;
            end else if (wr_stop && stop_idx == 2'(g)) begin
                module_stop[g] <= wdata;
            end
        end
    end
    for (g = 0; g < NBANK; g++) begin : g_bank
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                bank_regs[g] <= 32'h0000_0000;
            end else if (wr_bank && bank_idx == 5'(g)) begin
                bank_regs[g] <= wdata;
            end
        end
    end
endgenerate

// ==============================================================
// Read path: data captured in setup, answered in the access phase
logic [31:0] rd_mux;
always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_prot) begin
        rd_mux = {28'h000_0000, write_protect};
    end else if (hit_stop) begin
        rd_mux = module_stop[stop_idx];
    end else if (hit_pwr) begin
        rd_mux = {29'h0000_0000, power_mode_field};
    end else if (hit_ret) begin
        rd_mux = {24'h00_0000, return_clock_switch_enable, 4'h0, return_clock_select};
    end else if (hit_stat) begin
        rd_mux = {24'h00_0000, 3'h0, power_state};
    end else if (hit_bank) begin
        rd_mux = bank_regs[bank_idx];
    end
end

// Response packed in one assignment; combinational pready gives zero wait states
logic [31:0] rd_data;
logic        rd_err;
always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
        rd_data <= 32'h0000_0000;
        rd_err  <= 1'b0;
    end else if (acc_setup) begin
        rd_data <= rd_mux;
        rd_err  <= ~hit_any;
    end
end
assign apb_rsp = {apb_req.psel & apb_req.penable, rd_err, rd_data};

// ==============================================================
// Power state sequencing
wire ssby_sel   = bank_regs[`LPC_IDX_STBY][`LPC_STBY_SSBY];
wire snooze_en  = bank_regs[`LPC_IDX_SNZ][`LPC_SNZ_EN];
wire deep_en    = module_stop[2][`LPC_DEEP_SLEEP_ENABLE];

always_comb begin
    next_state = power_state;
    unique case (power_state)
        lpc_run: begin
            if (sleep_req) begin
                next_state = ssby_sel ? lpc_stby :
                             deep_en  ? lpc_deep : lpc_sleep;
            end
        end
        lpc_sleep, lpc_deep: begin
            if (wake_irq) begin
                next_state = lpc_run;
            end
        end
        lpc_stby: begin
            if (wake_irq) begin
                next_state = lpc_run;
            end else if (snooze_trigger && snooze_en) begin
                next_state = lpc_snooze;
            end
        end
        lpc_snooze: begin
            if (wake_irq) begin
                next_state = lpc_run;
            end else if (snooze_end) begin
                next_state = lpc_stby;
            end
        end
        default: next_state = lpc_run;
    endcase
end

// Clock switch requested only when leaving a sleep state with switching enabled
wire next_switch = return_clock_switch_enable & (next_state == lpc_run)
                 & ((power_state == lpc_sleep) | (power_state == lpc_deep));

always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
        power_state        <= lpc_run;
        clock_switch_pulse <= 1'b0;
    end else begin
        power_state        <= next_state;
        clock_switch_pulse <= next_switch;
    end
end

// ==============================================================
// Code decoders
wire [2:0] next_speed = (power_mode_field == `LPC_SPD_HIGH) ? 3'h1 :
                        (power_mode_field == `LPC_SPD_MID)  ? 3'h2 :
                        (power_mode_field == `LPC_SPD_MID2) ? 3'h4 : 3'h0;
// Undefined codes select nothing, so an illegal write cannot glitch two sources
wire [2:0] next_ret = (return_clock_select == `LPC_RET_LOW_SPEED_ONCHIP_OSC) ? 3'h1 :
                      (return_clock_select == `LPC_RET_HIGH_SPEED_ONCHIP_OSC) ? 3'h2 :
                      (return_clock_select == `LPC_RET_MAIN) ? 3'h4 : 3'h0;

always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
        speed_select        <= 3'h1;
        return_clock_onehot <= 3'h0;
    end else begin
        speed_select        <= next_speed;
        return_clock_onehot <= return_clock_switch_enable ? next_ret : 3'h0;
    end
end

// ==============================================================
// Unit gating: state only gates the clock, never clears unit contents
wire all_off  = (power_state == lpc_stby);
wire xfer_off = (power_state == lpc_deep);
generate
    for (g = 0; g < 4; g++) begin : g_unit
        logic [31:0] mode_allow;
        always_comb begin
            mode_allow = all_off ? 32'h0000_0000 : 32'hFFFF_FFFF;
            if (g == 0 && xfer_off) begin
                mode_allow[`LPC_XFER_STOP] = 1'b0;
            end
        end
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                unit_clock_enable[g] <= 32'h0000_0000;
                unit_retain[g]       <= 32'hFFFF_FFFF;
            end else begin
                unit_clock_enable[g] <= ~module_stop[g] & mode_allow;
                unit_retain[g]       <= module_stop[g] | ~mode_allow;
            end
        end
    end
endgenerate

// ==============================================================
// Checks
default clocking cb @(posedge sys_clk);
endclocking
default disable iff (sys_rst);

wire wr_stop_a_try = acc_write & (addr == 8'h04);
wire bank_clk_try  = acc_write & hit_bank & (bank_idx > `LPC_VDET_LAST);
wire bank_rt_try   = acc_write & hit_bank & (bank_idx > `LPC_LOWP_LAST)
                   & (bank_idx <= `LPC_RTMR_LAST);
wire bank_vd_try   = acc_write & hit_bank & (bank_idx > `LPC_RTMR_LAST)
                   & (bank_idx <= `LPC_VDET_LAST);

a_stop_guarded: assert property (
    wr_stop_a_try && !write_protect.lowp |=> $stable(module_stop[0]))
    else $error("Stop register changed while guarded");
a_clock_guarded: assert property (
    bank_clk_try && !write_protect.clk |=> $stable(bank_regs))
    else $error("Clock register changed while guarded");
a_timer_guarded: assert property (
    bank_rt_try && !write_protect.rtmr |=> $stable(bank_regs))
    else $error("Timer register changed while guarded");
a_vdet_guarded: assert property (
    bank_vd_try && !write_protect.vdet |=> $stable(bank_regs))
    else $error("Voltage register changed while guarded");
a_mode_open: assert property (
    acc_write && hit_pwr && write_protect.lowp |=> power_mode_field == $past(wdata[2:0]))
    else $error("Open power mode write lost");
a_deep_entry: assert property (
    power_state == lpc_run && sleep_req && !ssby_sel && deep_en |=> power_state == lpc_deep)
    else $error("Deep sleep not entered");
a_xfer_stop: assert property (
    module_stop[0][`LPC_XFER_STOP] |=> !unit_clock_enable[0][`LPC_XFER_STOP])
    else $error("Transfer controller runs while stopped");
a_can_stop: assert property (
    module_stop[1][`LPC_CAN_STOP] |=> !unit_clock_enable[1][`LPC_CAN_STOP])
    else $error("CAN runs while stopped");
a_unit_runs: assert property (
    power_state == lpc_sleep && !module_stop[3][0] ##1 !module_stop[3][0]
    |-> unit_clock_enable[3][0])
    else $error("Operable unit not enabled");
a_unit_retain: assert property (
    power_state == lpc_stby |=> unit_clock_enable == '0 && unit_retain == '1)
    else $error("Standby did not hold units");
a_snooze_enter: assert property (
    power_state == lpc_stby && !wake_irq && snooze_trigger && snooze_en
    |=> power_state == lpc_snooze)
    else $error("Snooze not entered");
a_snooze_exit: assert property (
    power_state == lpc_snooze && !wake_irq && snooze_end |=> power_state == lpc_stby)
    else $error("Snooze end did not return to standby");
a_speed_decode: assert property (
    power_mode_field == `LPC_SPD_MID2 ##1 power_mode_field == `LPC_SPD_MID2
    |-> speed_select == 3'h4)
    else $error("Middle speed 2 misdecoded");
a_ret_decode: assert property (
    return_clock_switch_enable && return_clock_select == `LPC_RET_HIGH_SPEED_ONCHIP_OSC
    |=> return_clock_onehot == 3'h2 || $changed(return_clock_select))
    else $error("Return clock misdecoded");
a_reset_state: assert property (
    $past(sys_rst) |-> write_protect == `LPC_PROT_RST && power_state == lpc_run
    && module_stop[1] == `LPC_MSTP_RST)
    else $error("Reset values not restored");
// Only one bank word can be written per edge, so only the addressed word is checked
a_bank_open: assert property (
    acc_write && hit_bank && bank_open |=> bank_regs[$past(bank_idx)] == $past(wdata))
    else $error("Open bank write lost");
a_guard_silent: assert property (
    acc_setup && hit_stop |=> !apb_rsp.pslverr)
    else $error("Stop register access flagged as error");
a_sleep_plain: assert property (
    power_state == lpc_run && sleep_req && !ssby_sel && !deep_en |=> power_state == lpc_sleep)
    else $error("Plain sleep not entered");
a_wake_run: assert property (
    power_state == lpc_snooze && wake_irq |=> power_state == lpc_run)
    else $error("Interrupt did not end snooze");

c_snooze_cycle: cover property (
    power_state == lpc_stby ##1 power_state == lpc_snooze ##[1:20] power_state == lpc_stby);
c_deep_wake: cover property (power_state == lpc_deep ##[1:20] clock_switch_pulse);
c_guarded_drop: cover property (wr_stop_a_try && !write_protect.lowp);
c_open_write: cover property (wr_bank);

endmodule

// [src/lpc_map.svh]
// Register map, field positions and reset values of the low power controller
`ifndef LPC_MAP_SVH
`define LPC_MAP_SVH
// ==============================================================
// Byte offsets
`define LPC_OFF_PROT    8'h00
`define LPC_OFF_MSTP    8'h04
`define LPC_OFF_PWR     8'h14
`define LPC_OFF_RET     8'h18
`define LPC_OFF_STAT    8'h1C
// ==============================================================
// Guarded bank: word index = offset[6:2] above 8'h80
`define LPC_BANK_WORDS  31
`define LPC_IDX_STBY    5'h00
`define LPC_IDX_SNZ     5'h02
`define LPC_LOWP_LAST   5'h06
`define LPC_RTMR_LAST   5'h0E
`define LPC_VDET_LAST   5'h16
// ==============================================================
// Field positions
`define LPC_STBY_SSBY   15
`define LPC_SNZ_EN      7
`define LPC_RET_EN      7
`define LPC_DEEP_SLEEP_ENABLE       31
`define LPC_XFER_STOP   28
`define LPC_CAN_STOP    0
// ==============================================================
// Codes and reset values
`define LPC_SPD_HIGH    3'h0
`define LPC_SPD_MID     3'h2
`define LPC_SPD_MID2    3'h4
`define LPC_RET_LOW_SPEED_ONCHIP_OSC    3'h0
`define LPC_RET_HIGH_SPEED_ONCHIP_OSC    3'h1
`define LPC_RET_MAIN    3'h2
`define LPC_MSTP_RST    32'hFFFF_FFFF
`define LPC_PROT_RST    4'h0
`endif

// [src/lpc_pkg.sv]
// Types shared by the low power controller and its bench
package lpc_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } lpc_apb_req_type;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } lpc_apb_rsp_type;
    typedef struct packed {
        logic vdet;
        logic rtmr;
        logic lowp;
        logic clk;
    } lpc_prot_type;
    typedef enum logic [4:0] {
        lpc_run    = 5'b00001,
        lpc_sleep  = 5'b00010,
        lpc_deep   = 5'b00100,
        lpc_stby   = 5'b01000,
        lpc_snooze = 5'b10000
    } lpc_mode_type;
endpackage

// [testbench/low_power_mode_control_tb.sv]
// Self-checking bench of the low power mode controller
`timescale 1ns/1ps
module low_power_mode_control_tb;
    import lpc_pkg::*;
    // ==============================================================
    // Signals
    logic              sys_clk;
    logic              sys_rst;
    lpc_apb_req_type   apb_req;
    lpc_apb_rsp_type   apb_rsp;
    logic [3:0]        ev;
    logic [3:0][31:0]  uce;
    logic [3:0][31:0]  urt;
    lpc_mode_type      pst;
    logic [2:0]        spd;
    logic [2:0]        rck;
    logic              csp;
    logic [30:0][31:0] bank;
    logic [15:0]       lfsr;
    logic [31:0]       q;
    logic [31:0]       r;
    logic [7:0]        a;
    logic [7:0]        v;
    logic              e;
    int                fail_count;
    int                tests_run;
    int                cyc;
    int                pulses;

    // Events: bit 3 sleep, 2 wake, 1 snooze trigger, 0 snooze end
    lpc_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .sleep_req(ev[3]), .wake_irq(ev[2]), .snooze_trigger(ev[1]), .snooze_end(ev[0]),
        .unit_clock_enable(uce), .unit_retain(urt), .power_state(pst), .speed_select(spd),
        .return_clock_onehot(rck), .clock_switch_pulse(csp), .bank_regs(bank));

    // ==============================================================
    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        pulses <= pulses + int'(csp);
        if (cyc == 5000) begin
            fail_count++;
            test_done;
        end
    end

    // ==============================================================
    // Expectations
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Protect bit that opens bank word i
    function automatic logic [3:0] guard(input int i);
        if (i <= 6) return 4'h2;
        if (i <= 14) return 4'h4;
        if (i <= 22) return 4'h8;
        return 4'h1;
    endfunction
    function automatic logic [2:0] spd_exp(input logic [2:0] c);
        case (c)
            3'h0: return 3'h1;
            3'h2: return 3'h2;
            3'h4: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction
    // Decode only counts while the switch enable bit is set
    function automatic logic [2:0] rck_exp(input logic [7:0] x);
        if (!x[7]) return 3'h0;
        case (x[2:0])
            3'h0: return 3'h1;
            3'h1: return 3'h2;
            3'h2: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction

    // ==============================================================
    // Tasks
    task automatic rnd(output logic [31:0] x);
        lfsr = step(lfsr);
        x[31:16] = lfsr;
        lfsr = step(lfsr);
        x[15:0] = lfsr;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chs(input lpc_mode_type x, input string m);
        chk({27'h0, pst}, {27'h0, x}, m);
    endtask
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        apb_req <= {1'b1, 1'b0, wr, ad, d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input string m);
        apb(1'b0, ad, 32'h0000_0000);
        chk(q, exp, m);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(input logic [3:0] x);
        @(posedge sys_clk);
        ev <= x;
        @(posedge sys_clk);
        ev <= 4'h0;
        #1;
    endtask
    task automatic do_reset;
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wt(1);
        chk(uce[0], 32'h0000_0000, "enables after reset");
        chk(urt[3], 32'hFFFF_FFFF, "retain after reset");
        chk({29'h0, spd}, 32'h0000_0001, "speed after reset");
        chs(lpc_run, "state after reset");
        rd(8'h00, 32'h0000_0000, "protect reset");
        rd(8'h04, 32'hFFFF_FFFF, "stop a reset");
        rd(8'h0C, 32'hFFFF_FFFF, "stop c reset");
        rd(8'h14, 32'h0000_0000, "mode reset");
        rd(8'h18, 32'h0000_0000, "return reset");
        rd(8'h1C, 32'h0000_0001, "status reset");
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==============================================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        apb_req = '0;
        ev = 4'h0;
        fail_count = 0;
        tests_run = 0;
        cyc = 0;
        pulses = 0;
        lfsr = 16'h005B;
        do_reset;
        apb(1'b1, 8'h04, 32'h0000_0000);
        rd(8'h04, 32'hFFFF_FFFF, "closed stop a");
        apb(1'b1, 8'hFC, 32'h1234_5678);
        chk({31'h0, e}, 32'h0000_0001, "unmapped write err");
        rd(8'hFC, 32'h0000_0000, "unmapped read");
        // Every other protect bit open must not unlock a word
        for (int i = 0; i < 31; i++) begin
            a = 8'h80 + 8'(4 * i);
            rnd(r);
            apb(1'b1, 8'h00, {28'h0, ~guard(i)});
            apb(1'b1, a, r);
            rd(a, 32'h0000_0000, "bank closed");
            apb(1'b1, 8'h00, {28'h0, guard(i)});
            apb(1'b1, a, r);
            rd(a, r, "bank open");
            chk(bank[i], r, "bank port");
        end
        apb(1'b1, 8'h00, 32'h0000_0002);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h14, 32'(2 * (c % 3)));
            wt(2);
            chk({29'h0, spd}, {29'h0, spd_exp(3'(2 * (c % 3)))}, "speed decode");
        end
        apb(1'b1, 8'h14, 32'h0000_0000);
        for (int k = 0; k < 16; k++) begin
            // Undefined select codes are only written with switching disabled
            v = {k[3] & (k[2:0] <= 3'h2), 4'h0, k[2:0]};
            apb(1'b1, 8'h18, {24'h0, v});
            wt(2);
            chk({29'h0, rck}, {29'h0, rck_exp(v)}, "return clock");
        end
        apb(1'b1, 8'h18, 32'h0000_0081);
        rnd(r);
        apb(1'b1, 8'h04, 32'h0000_0000);
        apb(1'b1, 8'h08, 32'h0000_0001);
        apb(1'b1, 8'h10, r);
        apb(1'b1, 8'h0C, 32'h0000_0000);
        apb(1'b1, 8'h80, 32'h0000_0000);
        apb(1'b1, 8'h88, 32'h0000_0000);
        wt(2);
        chk(uce[0], 32'hFFFF_FFFF, "stop a clear");
        chk(uce[1], 32'hFFFF_FFFE, "can stopped");
        chk(uce[3], ~r, "stop d enables");
        chk(urt[3], r, "stop d retain");
        pulse(4'h8);
        chs(lpc_sleep, "plain sleep");
        wt(2);
        chk(uce[0], 32'hFFFF_FFFF, "sleep keeps units");
        pulses = 0;
        pulse(4'h4);
        chs(lpc_run, "wake from sleep");
        wt(3);
        chk(32'(pulses), 32'h0000_0001, "switch pulse");
        apb(1'b1, 8'h0C, 32'h8000_0000);
        pulse(4'h8);
        chs(lpc_deep, "deep sleep");
        wt(2);
        chk(uce[0], 32'hEFFF_FFFF, "deep stops transfer");
        chk(urt[0], 32'h1000_0000, "deep retains transfer");
        chk(uce[1], 32'hFFFF_FFFE, "deep keeps others");
        pulse(4'h4);
        chs(lpc_run, "wake from deep");
        wt(2);
        chk(uce[0], 32'hFFFF_FFFF, "units back");
        pulse(4'h2);
        chs(lpc_run, "trigger in run");
        apb(1'b1, 8'h80, 32'h0000_8000);
        pulse(4'h8);
        chs(lpc_stby, "standby");
        wt(2);
        chk(uce[3], 32'h0000_0000, "standby stops all");
        rd(8'h1C, 32'h0000_0008, "status standby");
        pulse(4'h2);
        chs(lpc_stby, "snooze disabled");
        apb(1'b1, 8'h88, 32'h0000_0080);
        pulse(4'h2);
        chs(lpc_snooze, "snooze entry");
        pulse(4'h1);
        chs(lpc_stby, "snooze end");
        pulse(4'h2);
        pulse(4'h5);
        chs(lpc_run, "interrupt wins");
        do_reset;
        test_done;
    end
endmodule
